// ### logic/mhlf_defines.vh
`ifndef MHLF_DEFINES_VH
`define MHLF_DEFINES_VH
`define MHLF_CH_AT 8'h40
`define MHLF_CH_STAR 8'h2a
`define MHLF_CH_CR 8'h0d
`define MHLF_CH_ZERO 8'h30
`define MHLF_CH_LETTER_A 8'h41
`define MHLF_CH_LOW_A 8'h61
`define MHLF_CH_UPPER_F 8'h46
`define MHLF_CH_LOW_F 8'h66
`define MHLF_CH_NINE 8'h39
`define MHLF_CH_ERR0 8'h45
`define MHLF_CH_ERR1 8'h52
`define MHLF_PROTO_NATIVE 3'h5
`define MHLF_ID_RESET 8'h00
`define MHLF_FIFO_DEPTH 4
`define MHLF_FIFO_AW 2
`define MHLF_MAX_DATA 64
`endif

// ### logic/mhlf_fifo.v
`timescale 1ns/1ps
`default_nettype none
module mhlf_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 4,
    parameter AW = 2
) (
    input wire clk,
    input wire rst,
    input wire [WIDTH-1:0] in_data,
    input wire in_valid,
    output wire in_ready,
    output wire [WIDTH-1:0] out_data,
    output wire out_valid,
    input wire out_ready
);
    reg [WIDTH-1:0] mem_r [0:DEPTH-1];
    reg [AW-1:0] wr_r;
    reg [AW-1:0] rd_r;
    reg [AW:0] cnt_r;
    wire push;
    wire pop;
    assign in_ready = (cnt_r != DEPTH[AW:0]);
    assign out_valid = (cnt_r != {(AW+1){1'b0}});
    assign out_data = mem_r[rd_r];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    always @(posedge clk)
    begin
        if (push)
        begin
            mem_r[wr_r] <= in_data;
        end
    end
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            wr_r <= {AW{1'b0}};
            rd_r <= {AW{1'b0}};
            cnt_r <= {(AW+1){1'b0}};
        end
        else
        begin
            if (push)
            begin
                wr_r <= wr_r + 1'b1;
            end
            if (pop)
            begin
                rd_r <= rd_r + 1'b1;
            end
            if (push && !pop)
            begin
                cnt_r <= cnt_r + 1'b1;
            end
            else if (pop && !push)
            begin
                cnt_r <= cnt_r - 1'b1;
            end
        end
    end
endmodule // mhlf_fifo
`default_nettype wire

// ### logic/mhlf_framer.v
`timescale 1ns/1ps
`default_nettype none
`include "mhlf_defines.vh"
module mhlf_framer (
    input wire clk,
    input wire rst,
    input wire [7:0] own_id,
    input wire [2:0] protocol_select,
    input wire [7:0] rx_char,
    input wire rx_char_valid,
    output reg [7:0] cmd_char_r,
    output reg cmd_char_valid_r,
    output reg cmd_start_r,
    output reg cmd_end_r,
    input wire [7:0] resp_char,
    input wire resp_valid,
    output wire resp_ready,
    input wire resp_last,
    output reg [7:0] tx_char_r,
    output reg tx_char_valid_r,
    input wire tx_ready,
    input wire tx_busy,
    output reg line_drive_n_r,
    output reg frame_error_r
);
    localparam S_IDLE = 3'd0;
    localparam S_ID = 3'd1;
    localparam S_BODY = 3'd2;
    localparam S_CR = 3'd3;
    localparam S_EVAL = 3'd4;
    localparam S_REPLY = 3'd5;
    localparam S_FERR = 3'd6;
    localparam S_DRAIN = 3'd7;

    function [3:0] hex_val;
        input [7:0] c;
        begin
            if (c >= `MHLF_CH_ZERO && c <= `MHLF_CH_NINE)
                hex_val = c[3:0];
            else if ((c >= `MHLF_CH_LETTER_A && c <= `MHLF_CH_UPPER_F) ||
                     (c >= `MHLF_CH_LOW_A && c <= `MHLF_CH_LOW_F))
                hex_val = c[3:0] + 4'h9;
            else
                hex_val = 4'h0;
        end
    endfunction

    function [7:0] hex_char;
        input [3:0] n;
        begin
            if (n < 4'ha)
                hex_char = `MHLF_CH_ZERO + {4'h0, n};
            else
                hex_char = `MHLF_CH_LETTER_A + {4'h0, n - 4'ha};
        end
    endfunction

    reg [2:0] st_r;
    reg [1:0] idx_r;
    reg [7:0] tgt_r;
    reg [7:0] fcs_r;
    reg [7:0] prev1_r;
    reg [7:0] prev2_r;
    reg [7:0] fcs_prev2_r;
    reg [7:0] tx_fcs_r;
    reg [2:0] rsq_r;
    reg [7:0] rx_s1_r;
    reg [7:0] rx_s2_r;
    reg rxv_s1_r;
    reg rxv_s2_r;
    reg rxv_d_r;
    reg [7:0] buf_data_w;
    reg buf_valid_w;
    wire buf_ready;
    wire [7:0] q_data;
    wire q_valid;
    reg q_ready;
    wire rx_evt;
    wire [7:0] rx_c;

    assign rx_evt = rxv_s2_r && !rxv_d_r;
    assign rx_c = rx_s2_r;

    mhlf_fifo #(
        .WIDTH(8),
        .DEPTH(`MHLF_FIFO_DEPTH),
        .AW(`MHLF_FIFO_AW)
    ) u_fifo (
        .clk(clk),
        .rst(rst),
        .in_data(resp_char),
        .in_valid(resp_valid && st_r == S_REPLY),
        .in_ready(buf_ready),
        .out_data(q_data),
        .out_valid(q_valid),
        .out_ready(q_ready)
    );
    assign resp_ready = buf_ready && st_r == S_REPLY;

    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            rx_s1_r <= 8'h00;
            rx_s2_r <= 8'h00;
            rxv_s1_r <= 1'b0;
            rxv_s2_r <= 1'b0;
            rxv_d_r <= 1'b0;
        end
        else
        begin
            rx_s1_r <= rx_char;
            rx_s2_r <= rx_s1_r;
            rxv_s1_r <= rx_char_valid;
            rxv_s2_r <= rxv_s1_r;
            rxv_d_r <= rxv_s2_r;
        end
    end

    always @*
    begin
        q_ready = 1'b0;
        buf_data_w = 8'h00;
        buf_valid_w = 1'b0;
        if (st_r == S_REPLY || st_r == S_DRAIN)
        begin
            q_ready = tx_ready && !tx_char_valid_r && rsq_r == 3'd0;
        end
    end

    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            st_r <= S_IDLE;
            idx_r <= 2'd0;
            tgt_r <= 8'h00;
            fcs_r <= 8'h00;
            prev1_r <= 8'h00;
            prev2_r <= 8'h00;
            fcs_prev2_r <= 8'h00;
            tx_fcs_r <= 8'h00;
            rsq_r <= 3'd0;
            cmd_char_r <= 8'h00;
            cmd_char_valid_r <= 1'b0;
            cmd_start_r <= 1'b0;
            cmd_end_r <= 1'b0;
            tx_char_r <= 8'h00;
            tx_char_valid_r <= 1'b0;
            line_drive_n_r <= 1'b1;
            frame_error_r <= 1'b0;
        end
        else
        begin
            cmd_char_valid_r <= 1'b0;
            cmd_start_r <= 1'b0;
            cmd_end_r <= 1'b0;
            frame_error_r <= 1'b0;
            if (tx_char_valid_r && tx_ready)
            begin
                tx_char_valid_r <= 1'b0;
            end
            // Keep driving until the last reply character has left the transmitter.
            if (st_r != S_REPLY && st_r != S_FERR && st_r != S_DRAIN)
            begin
                line_drive_n_r <= !((tx_char_valid_r && !tx_ready) || tx_busy);
            end
            case (st_r)
            S_IDLE:
            begin
                if (rx_evt && rx_c == `MHLF_CH_AT)
                begin
                    fcs_r <= rx_c;
                    idx_r <= 2'd0;
                    st_r <= S_ID;
                end
            end
            S_ID:
            begin
                if (rx_evt)
                begin
                    fcs_r <= fcs_r ^ rx_c;
                    tgt_r <= {tgt_r[3:0], hex_val(rx_c)};
                    idx_r <= idx_r + 2'd1;
                    if (idx_r == 2'd1)
                    begin
                        st_r <= S_BODY;
                        prev1_r <= 8'h00;
                        prev2_r <= 8'h00;
                        idx_r <= 2'd0;
                    end
                end
            end
            S_BODY:
            begin
                if (rx_evt)
                begin
                    if (rx_c == `MHLF_CH_AT)
                    begin
                        fcs_r <= rx_c;
                        idx_r <= 2'd0;
                        st_r <= S_ID;
                    end
                    else if (rx_c == `MHLF_CH_STAR && idx_r == 2'd2)
                    begin
                        st_r <= S_CR;
                    end
                    else
                    begin
                        // The last two characters before the asterisk are the check field.
                        fcs_prev2_r <= fcs_r;
                        fcs_r <= fcs_r ^ rx_c;
                        prev2_r <= prev1_r;
                        prev1_r <= rx_c;
                        if (idx_r != 2'd2)
                        begin
                            idx_r <= idx_r + 2'd1;
                        end
                    end
                end
            end
            S_CR:
            begin
                if (rx_evt)
                begin
                    st_r <= (rx_c == `MHLF_CH_CR) ? S_EVAL : S_IDLE;
                end
            end
            S_EVAL:
            begin
                // Header and data end before the check field, so undo its two characters.
                st_r <= S_IDLE;
                if (tgt_r == own_id)
                begin
                    if ((prev2_r == `MHLF_CH_ZERO && prev1_r == `MHLF_CH_ZERO &&
                         protocol_select != `MHLF_PROTO_NATIVE) ||
                        ({hex_val(prev2_r), hex_val(prev1_r)} ==
                         (fcs_prev2_r ^ prev2_r)))
                    begin
                        cmd_end_r <= 1'b1;
                        tx_fcs_r <= `MHLF_CH_AT;
                        rsq_r <= 3'd1;
                        line_drive_n_r <= 1'b0;
                        st_r <= S_REPLY;
                    end
                    else
                    begin
                        frame_error_r <= 1'b1;
                        tx_fcs_r <= `MHLF_CH_AT;
                        rsq_r <= 3'd1;
                        line_drive_n_r <= 1'b0;
                        st_r <= S_FERR;
                    end
                end
            end
            S_REPLY, S_FERR, S_DRAIN:
            begin
                // Prefix: at sign then own ID; suffix: the two check characters only, with no asterisk or CR.
                if (tx_ready && !tx_char_valid_r)
                begin
                    if (rsq_r != 3'd0)
                    begin
                        tx_char_valid_r <= 1'b1;
                        rsq_r <= rsq_r + 3'd1;
                        case (rsq_r)
                        3'd1: tx_char_r <= `MHLF_CH_AT;
                        3'd2:
                        begin
                            tx_char_r <= hex_char(own_id[7:4]);
                            tx_fcs_r <= tx_fcs_r ^ hex_char(own_id[7:4]);
                        end
                        3'd3:
                        begin
                            tx_char_r <= hex_char(own_id[3:0]);
                            tx_fcs_r <= tx_fcs_r ^ hex_char(own_id[3:0]);
                            if (st_r == S_FERR)
                                rsq_r <= 3'd6;
                            else
                                rsq_r <= 3'd0;
                        end
                        3'd4: tx_char_r <= hex_char(tx_fcs_r[7:4]);
                        3'd5: tx_char_r <= hex_char(tx_fcs_r[3:0]);
                        3'd6:
                        begin
                            tx_char_r <= `MHLF_CH_ERR0;
                            tx_fcs_r <= tx_fcs_r ^ `MHLF_CH_ERR0;
                        end
                        3'd7:
                        begin
                            tx_char_r <= `MHLF_CH_ERR1;
                            tx_fcs_r <= tx_fcs_r ^ `MHLF_CH_ERR1;
                            rsq_r <= 3'd4;
                            st_r <= S_DRAIN;
                        end
                        default: tx_char_r <= 8'h00;
                        endcase
                        if (rsq_r == 3'd5)
                        begin
                            rsq_r <= 3'd0;
                            st_r <= S_IDLE;
                        end
                    end
                    else if (q_valid)
                    begin
                        tx_char_r <= q_data;
                        tx_char_valid_r <= 1'b1;
                        tx_fcs_r <= tx_fcs_r ^ q_data;
                    end
                    else if (st_r == S_DRAIN)
                    begin
                        rsq_r <= 3'd4;
                    end
                end
                if (st_r == S_REPLY && resp_valid && resp_ready && resp_last)
                begin
                    st_r <= S_DRAIN;
                end
            end
            default: st_r <= S_IDLE;
            endcase
            if (st_r == S_IDLE && rx_evt && rx_c != `MHLF_CH_AT)
            begin
                cmd_char_valid_r <= 1'b0;
            end
            if ((st_r == S_BODY) && rx_evt)
            begin
                cmd_char_r <= rx_c;
                cmd_start_r <= (idx_r == 2'd0) && (prev1_r == 8'h00);
            end
        end
    end
endmodule // mhlf_framer
`default_nettype wire

// ### sim/mhlf_framer_checker.sv
`timescale 1ns/1ps
`default_nettype none
module mhlf_framer_checker (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] tx_char_r,
    input wire logic tx_char_valid_r,
    input wire logic tx_ready,
    input wire logic resp_ready,
    input wire logic line_drive_n_r,
    input wire logic cmd_end_r,
    input wire logic frame_error_r
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    drive_on_tx_a: assert property (tx_char_valid_r |-> !line_drive_n_r)
        else $error("char offered while driver off");
    tx_hold_a: assert property (tx_char_valid_r && !tx_ready |=> tx_char_valid_r && $stable(tx_char_r))
        else $error("char dropped before accept");
    reply_cause_a: assert property ($fell(line_drive_n_r) |-> cmd_end_r || frame_error_r)
        else $error("driver on without a command");
    end_pulse_a: assert property (cmd_end_r |=> !cmd_end_r)
        else $error("command end not a pulse");
    err_pulse_a: assert property (frame_error_r |=> !frame_error_r)
        else $error("framing error not a pulse");
    one_verdict_a: assert property (!(cmd_end_r && frame_error_r))
        else $error("accept and error together");
    reply_lead_a: assert property (cmd_end_r || frame_error_r |-> ##[0:8] (tx_char_valid_r && tx_char_r == 8'h40))
        else $error("reply does not open with at sign");
    body_gate_a: assert property (resp_ready |-> !line_drive_n_r)
        else $error("body taken outside reply");
endmodule // mhlf_framer_checker
bind mhlf_framer mhlf_framer_checker chk_u (.clk(clk), .rst(rst), .tx_char_r(tx_char_r),
    .tx_char_valid_r(tx_char_valid_r), .tx_ready(tx_ready), .resp_ready(resp_ready),
    .line_drive_n_r(line_drive_n_r), .cmd_end_r(cmd_end_r), .frame_error_r(frame_error_r));
`default_nettype wire

// ### sim/mhlf_host.sv
`timescale 1ns/1ps
`default_nettype none
module mhlf_host (
    input wire logic clk,
    output logic [7:0] rx_char,
    output logic rx_char_valid,
    input wire logic [7:0] tx_char,
    input wire logic tx_valid,
    output logic tx_ready,
    input wire logic line_drive_n
);
    integer seed = 5;
    logic drive_en = 1'b0;
    logic [7:0] got [$];
    initial rx_char = 8'h00;
    initial rx_char_valid = 1'b0;
    initial tx_ready = 1'b0;
    // Random stalls make the device hold some reply characters.
    always @(negedge clk)
        tx_ready <= ($random(seed) & 3) != 0;
    always @(posedge clk)
        if (tx_valid && tx_ready)
            got.push_back(tx_char);
    task automatic begin_frame;
        begin
            while (!line_drive_n)
                @(negedge clk);
            repeat (2) @(negedge clk);
            drive_en = 1'b1;
        end
    endtask
    task automatic end_frame;
        drive_en = 1'b0;
    endtask
    // One character per rising edge of valid, same format for every node.
    task automatic send_char(input logic [7:0] c);
        begin
            rx_char = c;
            rx_char_valid = 1'b1;
            repeat (4) @(negedge clk);
            rx_char_valid = 1'b0;
            rx_char = ~c;
            repeat (4) @(negedge clk);
        end
    endtask
endmodule // mhlf_host
`default_nettype wire

// ### sim/mhlf_framer_tb.sv
`timescale 1ns/1ps
`default_nettype none
module mhlf_framer_tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] own_id = 8'h00;
    logic [2:0] protocol_select = 3'h0;
    logic [7:0] resp_char = 8'h00;
    logic resp_valid = 1'b0;
    logic resp_last = 1'b0;
    wire [7:0] rx_char;
    wire [7:0] tx_char_r;
    wire rx_char_valid, resp_ready, tx_char_valid_r, tx_ready;
    wire line_drive_n_r, cmd_end_r, frame_error_r;
    integer n_errors = 0;
    integer num_checks = 0;
    integer seed = 5;
    integer n_end = 0;
    integer n_ferr = 0;
    integer k;
    always #2.5 clk = ~clk;
    mhlf_framer dut_u (.clk(clk), .rst(rst), .own_id(own_id), .protocol_select(protocol_select),
        .rx_char(rx_char), .rx_char_valid(rx_char_valid), .cmd_char_r(), .cmd_char_valid_r(),
        .cmd_start_r(), .cmd_end_r(cmd_end_r), .resp_char(resp_char), .resp_valid(resp_valid),
        .resp_ready(resp_ready), .resp_last(resp_last), .tx_char_r(tx_char_r),
        .tx_char_valid_r(tx_char_valid_r), .tx_ready(tx_ready), .tx_busy(1'b0),
        .line_drive_n_r(line_drive_n_r), .frame_error_r(frame_error_r));
    mhlf_host host_u (.clk(clk), .rx_char(rx_char), .rx_char_valid(rx_char_valid),
        .tx_char(tx_char_r), .tx_valid(tx_char_valid_r), .tx_ready(tx_ready),
        .line_drive_n(line_drive_n_r));
    always @(posedge clk)
    begin
        if (cmd_end_r === 1'b1)
            n_end++;
        if (frame_error_r === 1'b1)
            n_ferr++;
    end
    function automatic logic [7:0] hexc(input logic [3:0] n);
        hexc = (n < 4'ha) ? 8'h30 + n : 8'h37 + n;
    endfunction
    task automatic check_val(input string what, input logic [31:0] exp, input logic [31:0] got);
        begin
            num_checks++;
            if (got !== exp)
            begin
                n_errors++;
                $display("wrong value %0s expected %h seen %h", what, exp, got);
            end
        end
    endtask
    task automatic wrap_up;
        begin
            $display("checks %0d errors %0d", num_checks, n_errors);
            if (n_errors == 0 && num_checks > 0)
                $display("verification passed");
            else
                $display("verification failed");
            $finish;
        end
    endtask
    // Mode 0 sends the true check, 1 the wildcard, 2 a corrupted check.
    task automatic run_cmd(input logic [7:0] id, input integer mode, input integer blen);
        logic [7:0] fr [$];
        logic [7:0] ex [$];
        logic [7:0] sum;
        logic [7:0] fld;
        logic acc;
        integer i;
        integer e0;
        integer f0;
        begin
            fr = {8'h40, hexc(id[7:4]), hexc(id[3:0])};
            for (i = 0; i < blen; i++)
                fr.push_back(8'h41 + 8'($random(seed) & 15));
            sum = 8'h00;
            foreach (fr[i])
                sum = sum ^ fr[i];
            fld = (mode == 0) ? sum : (mode == 1) ? 8'h00 : sum ^ 8'h01;
            acc = fld == sum || (fld == 8'h00 && protocol_select != 3'h5);
            acc = acc && id == own_id;
            ex = {};
            if (id == own_id)
            begin
                ex = acc ? fr : {fr[0], fr[1], fr[2], 8'h45, 8'h52};
                sum = 8'h00;
                foreach (ex[i])
                    sum = sum ^ ex[i];
                ex.push_back(hexc(sum[7:4]));
                ex.push_back(hexc(sum[3:0]));
            end
            host_u.got.delete();
            e0 = n_end;
            f0 = n_ferr;
            host_u.begin_frame();
            foreach (fr[i])
                host_u.send_char(fr[i]);
            host_u.send_char(hexc(fld[7:4]));
            host_u.send_char(hexc(fld[3:0]));
            host_u.send_char(8'h2a);
            host_u.send_char(8'h0d);
            host_u.end_frame();
            for (i = 3; acc && i < fr.size(); i++)
            begin
                resp_char = fr[i];
                resp_valid = 1'b1;
                resp_last = i == fr.size() - 1;
                while (resp_ready !== 1'b1)
                    @(negedge clk);
                @(posedge clk);
                @(negedge clk);
            end
            resp_valid = 1'b0;
            resp_last = 1'b0;
            for (i = 0; i < 400 && (host_u.got.size() < ex.size() || !line_drive_n_r); i++)
                @(negedge clk);
            repeat (20) @(negedge clk);
            check_val("reply length", ex.size(), host_u.got.size());
            foreach (ex[i])
                check_val("reply char", ex[i], host_u.got[i]);
            check_val("accepted count", acc, n_end - e0);
            check_val("error count", id == own_id && !acc, n_ferr - f0);
            check_val("driver idle", 1, line_drive_n_r);
        end
    endtask
    initial
    begin
        repeat (20000) @(posedge clk);
        n_errors++;
        wrap_up;
    end
    initial
    begin
        repeat (4) @(posedge clk);
        @(negedge clk);
        own_id = 8'ha5;
        rst = 1'b0;
        run_cmd(8'ha5, 0, 2);
        run_cmd(8'ha5, 2, 3);
        run_cmd(8'ha4, 0, 2);
        run_cmd(8'ha5, 1, 2);
        protocol_select = 3'h5;
        run_cmd(8'ha5, 1, 2);
        run_cmd(8'ha5, 0, 7);
        own_id = 8'hff;
        run_cmd(8'hff, 0, 1);
        for (k = 0; k < 8; k++)
        begin
            own_id = 8'($random(seed));
            protocol_select = 3'($random(seed));
            run_cmd(own_id ^ 8'($random(seed) & 1), $unsigned($random(seed)) % 3,
                1 + $unsigned($random(seed)) % 8);
        end
        rst = 1'b1;
        repeat (2) @(negedge clk);
        check_val("driver in reset", 1, line_drive_n_r);
        rst = 1'b0;
        own_id = 8'h00;
        run_cmd(8'h00, 0, 4);
        wrap_up;
    end
endmodule // mhlf_framer_tb
`default_nettype wire
